// [slp_regs.svh]
`ifndef SLP_REGS_SVH
`define SLP_REGS_SVH

// ==========================================================
// register offsets
`define SLP_OFS_CHAN_CFG   16'h0200
`define SLP_OFS_DECIM      16'h0201
`define SLP_OFS_LANE_RATE  16'h056e
`define SLP_OFS_PLL_STAT   16'h056f
`define SLP_OFS_LINK_MODE  16'h0570
`define SLP_OFS_LINK_CTRL  16'h0571
`define SLP_OFS_NPRIME     16'h058f
`define SLP_OFS_SUBCLASS   16'h0590
`define SLP_OFS_DEEMPH     16'h05c4
`define SLP_OFS_LOL_CLR    16'h1262

// ==========================================================
// reset values
`define SLP_RST_LANE_RATE  8'h30
`define SLP_RST_LINK_MODE  8'h00
`define SLP_RST_LINK_CTRL  8'h14
`define SLP_RST_NPRIME     8'h0f
`define SLP_RST_SUBCLASS   8'h2f
`define SLP_RST_CHAN_CFG   8'h00
`define SLP_RST_DECIM      8'h01
`define SLP_RST_DEEMPH     8'h00

// ==========================================================
// field values and positions
`define SLP_RATE_MID       8'h00
`define SLP_RATE_LOW       8'h10
`define SLP_RATE_HIGH      8'h30
`define SLP_RATE_VLOW      8'h50
`define SLP_MODE_PACK      8'hfd
`define SLP_RESTART_A      8'h15
`define SLP_RESTART_B      8'h14
`define SLP_LOL_CLR_VAL    8'h08
`define SLP_STAT_LOCK_BIT  7
`define SLP_STAT_LOL_BIT   3
`define SLP_CTRL_PDN_BIT   0
`define SLP_PACK_SPARE     4'h0
`define SLP_PACK_LAST      3'h4
`define SLP_LANES_PACK     8'h0f
`define SLP_LANES_ALL      8'hff

`endif

// [slp_pkg.sv]
package slp_pkg;

    // ==========================================================
    // lane-rate band
    typedef enum logic [2:0]
    {
        SLP_BAND_MID  = 3'b000,
        SLP_BAND_LOW  = 3'b001,
        SLP_BAND_HIGH = 3'b010,
        SLP_BAND_VLOW = 3'b011,
        SLP_BAND_BAD  = 3'b100
    } slp_band_e;

    // ==========================================================
    // top-level state
    typedef struct packed {
        logic [7:0]  lane_rate;
        logic [7:0]  link_mode;
        logic [7:0]  link_ctrl;
        logic [7:0]  nprime;
        logic [7:0]  subclass;
        logic [7:0]  chan_cfg;
        logic [7:0]  decim;
        logic [7:0]  deemph;
        slp_band_e   band;
        logic [7:0]  lane_en;
        logic        pack;
        logic        restart_arm;
        logic        lock_s1;
        logic        lock_s2;
        logic        lock_s3;
        logic        lock;
        logic        lock_lost_sticky;
        logic        sync_s1;
        logic        sync_s2;
        logic        sync_s3;
        logic        sync_n;
        logic        ilas_pend;
        logic        ilas_start;
        logic [7:0]  rdata;
        logic        rvalid;
        logic [47:0] acc;
        logic [2:0]  cnt;
        logic        pend;
        logic [63:0] frame;
        logic        samp_ready;
    } slp_state_s;

endpackage

// [slp_link_setup.sv]
`include "slp_regs.svh"

// ==========================================================
// frame fifo with registered output stage
module slp_fifo
#(
    parameter int W = 64,
    parameter int D = 8
)
(
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // fill side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // drain side
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [CW-1:0]       cnt;
        logic                ov;
        logic [W-1:0]        od;
    } slp_fifo_s;

    slp_fifo_s st_q;
    slp_fifo_s st_d;
    logic      push;
    logic      pop;

    assign in_ready_o  = (st_q.cnt != CW'(D));
    assign out_valid_o = st_q.ov;
    assign out_data_o  = st_q.od;

    always_comb
    begin
        st_d = st_q;
        push = in_valid_i && in_ready_o;
        pop  = (st_q.cnt != '0) && (!st_q.ov || out_ready_i);
        if (out_ready_i)
        begin
            st_d.ov = 1'b0;
        end
        if (pop)
        begin
            st_d.ov = 1'b1;
            st_d.od = st_q.mem[st_q.rp];
            st_d.rp = (st_q.rp == AW'(D - 1)) ? '0 : st_q.rp + 1'b1;
        end
        if (push)
        begin
            st_d.mem[st_q.wp] = in_data_i;
            st_d.wp = (st_q.wp == AW'(D - 1)) ? '0 : st_q.wp + 1'b1;
        end
        st_d.cnt = st_q.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            st_q <= '0;
        end
        else if (ce_i)
        begin
            st_q <= st_d;
        end
    end
endmodule

// Behaviour
// R1: de-emphasis is off after reset; software enables it only for lossy links.
// R2: status register bit 7 reads the serializer pll locked indication.
// R3: status register bit 3 is a sticky loss-of-lock flag.
// R4: writing 0x15 then 0x14 to link control restarts link, clears sticky flag.
// R5: software programs lane-rate bits 7:4 to match the real lane rate.
// R6: lane-rate value decodes to four bands, 0x30 being the reset default.
// R7: packing mode packs five 12-bit samples plus four spare bits per 64-bit frame.
// R8: packing mode link uses four lanes, one converter, 16-bit samples.
// R9: software enters packing mode by writing 0xfd, 0x0f, 0x2f and lane rate.
// R10: packing mode lane rate is sample rate times 16 over lane count.
// R11: software uses packing only with channel configuration at full bandwidth.
// R12: software reruns link initialization after every kind of reset.
// R13: initialization writes go to start-up, pll calibration, loss-of-lock clear.
// R14: all eight lanes form one link; lane count sets which are used.
// R15: lane rate follows converters, sample width and decimated rate, under 16 Gbps.
// R16: software configures the output in the prescribed power-down-to-init order.
// R17: below 6.25 Gbps software selects the low band by writing 0x10.
// R18: software picks configurations whose lane rate lies from 3.4 to 16 Gbps.
// R19: single-converter configurations use one, two or four lanes.
// R20: decimation register value is the decimation ratio used by the link.
// R21: after sync request release, alignment starts on the next multiframe boundary.
// R22: spare bits of each packed frame are fixed at zero.
// R23: sticky flag sets on the first cycle lock falls, not cleared by relock.
module slp_link_setup
    import slp_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
)
(
    // clock, reset, enable
    input  wire logic           ref_clk_i,
    input  wire logic           rst_i,
    input  wire logic           ce_i,
    // register port
    input  wire logic [15:0]    reg_addr_i,
    input  wire logic           reg_wr_i,
    input  wire logic [7:0]     reg_wdata_i,
    input  wire logic           reg_rd_i,
    output logic [7:0]          reg_rdata_o,
    output logic                reg_rvalid_o,
    // serializer pll and link partner
    input  wire logic           pll_lock_i,
    input  wire logic           sync_req_n_i,
    input  wire logic           lmfc_i,
    output logic                ilas_start_o,
    // link setup outputs
    output slp_pkg::slp_band_e  lane_band_o,
    output logic [7:0]          lane_en_o,
    output logic                pack_mode_o,
    output logic                deemph_en_o,
    output logic                link_pdn_o,
    output logic [7:0]          decimation_ratio_o,
    // sample input
    input  wire logic           samp_valid_i,
    input  wire logic [11:0]    samp_data_i,
    output logic                samp_ready_o,
    // packed frame output
    output logic                frame_valid_o,
    output logic [63:0]         frame_data_o,
    input  wire logic           frame_ready_i
);
    import slp_pkg::*;

    slp_state_s st_q;
    slp_state_s st_d;
    logic       fifo_in_ready;
    logic       lol_set;
    logic       lol_clr;
    logic       wr_ctrl;

    // ==========================================================
    // band decode
    function automatic slp_band_e band_of(input logic [7:0] v);
        unique case (v)
            `SLP_RATE_MID:  band_of = SLP_BAND_MID;
            `SLP_RATE_LOW:  band_of = SLP_BAND_LOW;
            `SLP_RATE_HIGH: band_of = SLP_BAND_HIGH;
            `SLP_RATE_VLOW: band_of = SLP_BAND_VLOW;
            default:        band_of = SLP_BAND_BAD;
        endcase
    endfunction

    // ==========================================================
    // outputs
    assign reg_rdata_o        = st_q.rdata;
    assign reg_rvalid_o       = st_q.rvalid;
    assign ilas_start_o       = st_q.ilas_start;
    assign lane_band_o        = st_q.band;
    assign lane_en_o          = st_q.lane_en;
    assign pack_mode_o        = st_q.pack;
    assign deemph_en_o        = st_q.deemph[0];
    assign link_pdn_o         = st_q.link_ctrl[`SLP_CTRL_PDN_BIT];
    assign decimation_ratio_o = st_q.decim;
    assign samp_ready_o       = st_q.samp_ready;

    // ==========================================================
    // next state
    always_comb
    begin
        st_d = st_q;
        wr_ctrl = reg_wr_i && (reg_addr_i == `SLP_OFS_LINK_CTRL);
        // register writes
        if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                `SLP_OFS_LANE_RATE: st_d.lane_rate = reg_wdata_i; // R5
                `SLP_OFS_LINK_MODE: st_d.link_mode = reg_wdata_i;
                `SLP_OFS_LINK_CTRL: st_d.link_ctrl = reg_wdata_i;
                `SLP_OFS_NPRIME:    st_d.nprime    = reg_wdata_i;
                `SLP_OFS_SUBCLASS:  st_d.subclass  = reg_wdata_i;
                `SLP_OFS_CHAN_CFG:  st_d.chan_cfg  = reg_wdata_i;
                `SLP_OFS_DECIM:     st_d.decim     = reg_wdata_i; // R20 R15
                `SLP_OFS_DEEMPH:    st_d.deemph    = reg_wdata_i; // R1
                default:            st_d.rvalid    = st_q.rvalid;
            endcase
        end
        st_d.band = band_of(st_d.lane_rate); // R6
        // link restart sequence
        lol_clr = 1'b0;
        if (wr_ctrl)
        begin
            st_d.restart_arm = (reg_wdata_i == `SLP_RESTART_A);
            lol_clr = st_q.restart_arm && (reg_wdata_i == `SLP_RESTART_B); // R4
        end
        if (reg_wr_i && (reg_addr_i == `SLP_OFS_LOL_CLR) && (reg_wdata_i == `SLP_LOL_CLR_VAL))
        begin
            lol_clr = 1'b1;
        end
        // pll lock synchroniser and sticky loss flag
        st_d.lock_s1 = pll_lock_i;
        st_d.lock_s2 = st_q.lock_s1;
        st_d.lock_s3 = st_q.lock_s2;
        if (st_q.lock_s2 == st_q.lock_s3)
        begin
            st_d.lock = st_q.lock_s3; // R2
        end
        lol_set = st_q.lock && !st_d.lock; // R23
        st_d.lock_lost_sticky = lol_set || (st_q.lock_lost_sticky && !lol_clr); // R3
        // sync request release and alignment start
        st_d.sync_s1 = sync_req_n_i;
        st_d.sync_s2 = st_q.sync_s1;
        st_d.sync_s3 = st_q.sync_s2;
        if (st_q.sync_s2 == st_q.sync_s3)
        begin
            st_d.sync_n = st_q.sync_s3;
        end
        st_d.ilas_start = 1'b0;
        if (!st_d.sync_n)
        begin
            st_d.ilas_pend = 1'b0;
        end
        else if (!st_q.sync_n)
        begin
            st_d.ilas_pend = 1'b1;
        end
        else if (st_q.ilas_pend && lmfc_i)
        begin
            st_d.ilas_pend  = 1'b0;
            st_d.ilas_start = 1'b1; // R21
        end
        // register reads
        st_d.rvalid = reg_rd_i;
        st_d.rdata  = 8'h00;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `SLP_OFS_LANE_RATE: st_d.rdata = st_q.lane_rate;
                `SLP_OFS_PLL_STAT:
                begin
                    st_d.rdata[`SLP_STAT_LOCK_BIT] = st_q.lock; // R2
                    st_d.rdata[`SLP_STAT_LOL_BIT]  = st_q.lock_lost_sticky;  // R3
                end
                `SLP_OFS_LINK_MODE: st_d.rdata = st_q.link_mode;
                `SLP_OFS_LINK_CTRL: st_d.rdata = st_q.link_ctrl;
                `SLP_OFS_NPRIME:    st_d.rdata = st_q.nprime;
                `SLP_OFS_SUBCLASS:  st_d.rdata = st_q.subclass;
                `SLP_OFS_CHAN_CFG:  st_d.rdata = st_q.chan_cfg;
                `SLP_OFS_DECIM:     st_d.rdata = st_q.decim;
                `SLP_OFS_DEEMPH:    st_d.rdata = st_q.deemph;
                default:            st_d.rdata = 8'h00;
            endcase
        end
        // packing mode and lane use
        st_d.pack = (st_d.link_mode == `SLP_MODE_PACK); // R8 R10
        st_d.lane_en = st_d.pack ? `SLP_LANES_PACK : `SLP_LANES_ALL; // R14 R19
        // sample packer
        if (st_q.pend && fifo_in_ready)
        begin
            st_d.pend = 1'b0;
        end
        if (!st_q.pack)
        begin
            st_d.cnt = 3'h0;
        end
        else if (samp_valid_i && st_q.samp_ready)
        begin
            if (st_q.cnt == `SLP_PACK_LAST)
            begin
                st_d.frame = {`SLP_PACK_SPARE, samp_data_i, st_q.acc}; // R7 R22
                st_d.pend  = 1'b1;
                st_d.cnt   = 3'h0;
            end
            else
            begin
                st_d.acc = {samp_data_i, st_q.acc[47:12]};
                st_d.cnt = st_q.cnt + 3'h1;
            end
        end
        st_d.samp_ready = st_d.pack && !st_d.pend;
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            st_q           <= '0;
            st_q.lane_rate <= `SLP_RST_LANE_RATE;
            st_q.link_mode <= `SLP_RST_LINK_MODE;
            st_q.link_ctrl <= `SLP_RST_LINK_CTRL;
            st_q.nprime    <= `SLP_RST_NPRIME;
            st_q.subclass  <= `SLP_RST_SUBCLASS;
            st_q.chan_cfg  <= `SLP_RST_CHAN_CFG;
            st_q.decim     <= `SLP_RST_DECIM;
            st_q.deemph    <= `SLP_RST_DEEMPH; // R1
            st_q.band      <= SLP_BAND_HIGH;
            st_q.lane_en   <= `SLP_LANES_ALL;
            st_q.sync_s1   <= 1'b1;
            st_q.sync_s2   <= 1'b1;
            st_q.sync_s3   <= 1'b1;
            st_q.sync_n    <= 1'b1;
        end
        else if (ce_i)
        begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // frame buffer
    slp_fifo
    #(
        .W (64),
        .D (FIFO_DEPTH)
    )
    u_fifo
    (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_valid_i  (st_q.pend),
        .in_data_i   (st_q.frame),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (frame_valid_o),
        .out_data_o  (frame_data_o),
        .out_ready_i (frame_ready_i)
    );

    // ==========================================================
    // checks
    sequence s_lock_drop;
        ce_i && st_q.lock && !st_d.lock;
    endsequence

    sequence s_restart;
        ce_i && wr_ctrl && st_q.restart_arm && (reg_wdata_i == `SLP_RESTART_B);
    endsequence

    a_lol_on_fall: assert property ( // R23
        @(posedge ref_clk_i) disable iff (rst_i) s_lock_drop |=> st_q.lock_lost_sticky)
        else $error("sticky flag not set on lock fall");

    a_lol_holds: assert property ( // R3
        @(posedge ref_clk_i) disable iff (rst_i) (st_q.lock_lost_sticky && !lol_clr) |=> st_q.lock_lost_sticky)
        else $error("sticky flag cleared without restart");

    a_restart_clears: assert property ( // R4
        @(posedge ref_clk_i) disable iff (rst_i) (s_restart and !lol_set) |=> !st_q.lock_lost_sticky)
        else $error("restart did not clear sticky flag");

    a_lock_read_bit: assert property ( // R2
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && reg_rd_i && reg_addr_i == `SLP_OFS_PLL_STAT)
        |=> reg_rvalid_o && (reg_rdata_o[`SLP_STAT_LOCK_BIT] == $past(st_q.lock)))
        else $error("lock bit read wrong");

    a_band_decode: assert property ( // R6
        @(posedge ref_clk_i) disable iff (rst_i) lane_band_o == band_of(st_q.lane_rate))
        else $error("lane band mismatch");

    a_rate_default: assert property ( // R6
        @(posedge ref_clk_i) rst_i |=> st_q.lane_rate == `SLP_RST_LANE_RATE && !deemph_en_o)
        else $error("reset defaults wrong");

    a_ilas_boundary: assert property ( // R21
        @(posedge ref_clk_i) disable iff (rst_i) $rose(ilas_start_o) |-> $past(lmfc_i) && st_q.sync_n)
        else $error("alignment start off boundary");

    a_pack_frame: assert property ( // R7
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(st_q.pend) |-> st_q.frame[63:60] == `SLP_PACK_SPARE && st_q.frame[59:48] == $past(samp_data_i))
        else $error("packed frame layout wrong");

    a_pack_lanes: assert property ( // R8
        @(posedge ref_clk_i) disable iff (rst_i) pack_mode_o |-> lane_en_o == `SLP_LANES_PACK)
        else $error("packing mode lane set wrong");
endmodule

// [slp_rx_model.sv]
module slp_rx_model
(
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // bench controls
    input  wire logic stall_i,
    input  wire logic resync_i,
    // receiver side
    output logic      sync_req_n_o,
    output logic      lmfc_o,
    output logic      frame_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] mf_cnt;
    logic [3:0] hold_cnt;
    logic [7:0] lfsr;

    // ==========================================================
    // multiframe tick, sync request, drain pacing
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            mf_cnt   <= 3'h0;
            hold_cnt <= 4'h0;
            lfsr     <= 8'h5a;
        end
        else
        begin
            mf_cnt <= mf_cnt + 3'h1;
            lfsr   <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            if (resync_i)
                hold_cnt <= 4'hc;
            else if (hold_cnt != 4'h0)
                hold_cnt <= hold_cnt - 4'h1;
        end
    end

    assign sync_req_n_o  = (hold_cnt == 4'h0);
    assign lmfc_o        = (mf_cnt == 3'h7);
    assign frame_ready_o = !stall_i && (lfsr[0] || lfsr[2]);
endmodule

// [tb_serial_link_setup_packing.sv]
module tb_serial_link_setup_packing;
    import slp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst, ce, wr, rd, rvalid, lock, sv, sr, fv, fr;
    logic        sync_n, lmfc, ilas, pack, deemph, pdn, stall, resync;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata, lane_en, decim, v;
    logic [11:0] sd;
    logic [63:0] fd;
    logic [59:0] acc;
    logic [31:0] rs;
    slp_band_e   band;
    logic [63:0] q[$];
    logic [7:0]  rates[5] = '{8'h00, 8'h10, 8'h30, 8'h50, 8'h70};
    int          n_fail, tests_run, cnt, n_ilas;
    logic        took, lmfc_prev;

    slp_link_setup uut (.ref_clk_i(clk), .rst_i(rst), .ce_i(ce), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .pll_lock_i(lock), .sync_req_n_i(sync_n), .lmfc_i(lmfc),
        .ilas_start_o(ilas), .lane_band_o(band), .lane_en_o(lane_en), .pack_mode_o(pack),
        .deemph_en_o(deemph), .link_pdn_o(pdn), .decimation_ratio_o(decim),
        .samp_valid_i(sv), .samp_data_i(sd), .samp_ready_o(sr), .frame_valid_o(fv),
        .frame_data_o(fd), .frame_ready_i(fr));

    slp_rx_model rx (.ref_clk_i(clk), .rst_i(rst), .stall_i(stall), .resync_i(resync),
        .sync_req_n_o(sync_n), .lmfc_o(lmfc), .frame_ready_o(fr));

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic slp_band_e band_of(input logic [7:0] r);
        case (r)
            8'h00:   return SLP_BAND_MID;
            8'h10:   return SLP_BAND_LOW;
            8'h30:   return SLP_BAND_HIGH;
            8'h50:   return SLP_BAND_VLOW;
            default: return SLP_BAND_BAD;
        endcase
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd   = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk({rvalid, rdata}, {1'b1, e});
    endtask

    task automatic send(input int n);
        repeat (n)
        begin
            @(negedge clk);
            if (took || !sv)
            begin
                sd = rs[11:0];
                sv = rs[20] | rs[21];
                rs = xs(rs);
            end
        end
    endtask

    task automatic fin;
        @(negedge clk);
        while (sv && !took) @(negedge clk);
        sv = 1'b0;
    endtask

    task automatic summarize;
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // clock, monitors, watchdog
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
    begin
        took = sv && sr === 1'b1;
        if (pack !== 1'b1)
            cnt = 0;
        else if (took)
        begin
            acc = {sd, acc[59:12]};
            cnt++;
        end
        if (cnt == 5)
        begin
            q.push_back({4'h0, acc});
            cnt = 0;
        end
        if (fv === 1'b1 && fr === 1'b1)
        begin
            if (q.size() == 0)
                chk(1, 0);
            else
                chk(fd, q.pop_front());
        end
        if (ilas === 1'b1)
        begin
            n_ilas++;
            chk(lmfc_prev, 1);
        end
        lmfc_prev = lmfc;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        {ce, wr, rd, lock, sv, stall, resync, took, lmfc_prev} = 9'h100;
        {addr, wdata, sd, acc, cnt, n_ilas, n_fail, tests_run} = '0;
        rs  = 32'd43252;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rd_chk(16'h056e, 8'h30);
        rd_chk(16'h056f, 8'h00);
        rd_chk(16'h05c4, 8'h00);
        rd_chk(16'h0123, 8'h00);
        chk(deemph, 0);
        chk(lane_en, 8'hff);
        chk(decim, 1);
        foreach (rates[i])
        begin
            wr_reg(16'h056e, rates[i]);
            cyc(2);
            chk(band, band_of(rates[i]));
            rd_chk(16'h056e, rates[i]);
        end
        v = rs[7:0];
        rs = xs(rs);
        wr_reg(16'h0201, v);
        cyc(2);
        chk(decim, v);
        wr_reg(16'h05c4, 8'h01);
        cyc(2);
        chk(deemph, 1);
        wr_reg(16'h056f, 8'hff);
        rd_chk(16'h056f, 8'h00);
        lock = 1'b1;
        cyc(8);
        rd_chk(16'h056f, 8'h80);
        lock = 1'b0;
        cyc(8);
        rd_chk(16'h056f, 8'h08);
        lock = 1'b1;
        cyc(8);
        rd_chk(16'h056f, 8'h88);
        wr_reg(16'h0571, 8'h14);
        rd_chk(16'h056f, 8'h88);
        wr_reg(16'h0571, 8'h15);
        cyc(2);
        chk(pdn, 1);
        wr_reg(16'h0571, 8'h14);
        cyc(2);
        chk(pdn, 0);
        rd_chk(16'h056f, 8'h80);
        lock = 1'b0;
        cyc(8);
        lock = 1'b1;
        cyc(8);
        wr_reg(16'h1262, 8'h08);
        wr_reg(16'h1262, 8'h00);
        rd_chk(16'h056f, 8'h80);
        wr_reg(16'h0200, 8'h00);
        wr_reg(16'h0570, 8'hfd);
        wr_reg(16'h058f, 8'h0f);
        wr_reg(16'h0590, 8'h2f);
        wr_reg(16'h056e, 8'h00);
        cyc(2);
        chk(pack, 1);
        chk(lane_en, 8'h0f);
        send(43);
        fin();
        wr_reg(16'h0570, 8'h00);
        wr_reg(16'h0570, 8'hfd);
        cyc(2);
        send(40);
        fin();
        cyc(60);
        chk(q.size(), 0);
        stall = 1'b1;
        send(150);
        chk(sr, 0);
        chk(q.size() >= 8, 1);
        stall = 1'b0;
        fin();
        cyc(120);
        chk(q.size(), 0);
        n_ilas = 0;
        resync = 1'b1;
        @(negedge clk);
        resync = 1'b0;
        cyc(60);
        chk(n_ilas, 1);
        // ==========================================================
        // mid-run reset, ordered bring-up, init writes, frozen enable
        @(negedge clk);
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        chk({rvalid, ilas, pack, fv, sr, lane_en}, {5'h00, 8'hff});
        rd_chk(16'h056e, 8'h30);
        wr_reg(16'h0571, 8'h15);
        wr_reg(16'h0570, 8'hfd);
        wr_reg(16'h0571, 8'h14);
        wr_reg(16'h1228, 8'h4f);
        wr_reg(16'h1228, 8'h0f);
        wr_reg(16'h1222, 8'h00);
        wr_reg(16'h1222, 8'h04);
        wr_reg(16'h1222, 8'h00);
        wr_reg(16'h1262, 8'h08);
        wr_reg(16'h1262, 8'h00);
        rd_chk(16'h056f, 8'h80);
        chk(pack, 1);
        chk(pdn, 0);
        ce = 1'b0;
        wr_reg(16'h0201, 8'h55);
        ce = 1'b1;
        cyc(2);
        chk(decim, 1);
        summarize();
    end
endmodule
